// file: rtl/gst_pin_sync.v
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Three stage pin synchroniser with agreement filter
// ----------------------------------------------------------------
module gst_pin_sync
(
    input  wire ref_clk_i,
    input  wire rst_n_i,
    input  wire clk_en_i,
    input  wire pin_i,
    output reg  level_o
);

    reg stage1;
    reg stage2;
    reg stage3;

    always @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            stage1  <= 1'b0;
            stage2  <= 1'b0;
            stage3  <= 1'b0;
            level_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            stage1 <= pin_i;
            stage2 <= stage1;
            stage3 <= stage2;
            // Change counts once second and third agree
            if (stage2 == stage3)
            begin
                level_o <= stage3;
            end
        end
    end

endmodule // gst_pin_sync

// file: rtl/gst_regs.vh
`ifndef GST_REGS_VH
`define GST_REGS_VH

// ----------------------------------------------------------------
// Counter layout
// ----------------------------------------------------------------
`define GST_CNT_W        16
`define GST_BYTE_W       8
`define GST_CNT_RST      16'h0000
`define GST_CNT_ALL_ONES 16'hffff
`define GST_CNT_ONE      16'h0001
`define GST_HI_MSB       15
`define GST_HI_LSB       8
`define GST_LO_MSB       7
`define GST_LO_LSB       0

// ----------------------------------------------------------------
// Clock select encodings
// ----------------------------------------------------------------
`define GST_CS_W         2
`define GST_CS_INSTR     2'h0
`define GST_CS_FOSC      2'h1
`define GST_CS_EXT       2'h2
`define GST_CS_NONE      2'h3

// ----------------------------------------------------------------
// Gate source encodings
// ----------------------------------------------------------------
`define GST_GS_W         3
`define GST_GS_CELL1     3'h0
`define GST_GS_CELL2     3'h1
`define GST_GS_CELL3     3'h2
`define GST_GS_CELL4     3'h3
`define GST_GS_ZCD       3'h4
`define GST_GS_CMP1      3'h5
`define GST_GS_CMP2      3'h6
`define GST_GS_PIN       3'h7

// ----------------------------------------------------------------
// Pin input positions in the synchroniser bank
// ----------------------------------------------------------------
`define GST_PIN_N        9
`define GST_PIN_EXT      8

// ----------------------------------------------------------------
// Prescaler and instruction cycle timing
// ----------------------------------------------------------------
`define GST_PS_W         2
`define GST_PS_CNT_W     3
`define GST_PS_CNT_RST   3'h0
`define GST_PS_ONE       3'h1
`define GST_PHASE_W      2
`define GST_PHASE_RST    2'h0
`define GST_PHASE_ONE    2'h1
`define GST_PHASE_LAST   2'h3
`define GST_PS_DIV1      2'h0
`define GST_PS_DIV2      2'h1
`define GST_PS_DIV4      2'h2
`define GST_PS_DIV8      2'h3
`define GST_PS_TOP1      3'h0
`define GST_PS_TOP2      3'h1
`define GST_PS_TOP4      3'h3
`define GST_PS_TOP8      3'h7

`endif

// file: rtl/gst_timer.v
// What this block does
// [R1] Sixteen bit up-counter, reachable as high byte and low byte.
// [R2] Writing either byte loads it into the running count at once.
// [R3] Internal source advances the count once every instruction cycle.
// [R4] External source, timer on: count each rising edge of external input.
// [R5] Counts only with on bit; gate enable makes counting follow the gate.
// [R6] Clock select input picks the source that increments the counter.
// [R7] Oscillator source increments per oscillator tick through the prescaler.
// [R8] Oscillator source gives four counts per instruction cycle.
// [R9] Gate picks from four logic cells, zero-cross, two comparators, gate pin.
// [R10] External source counts synchronised to instruction cycle or at once.
// [R11] Counter mode needs a falling edge before first counted rising edge.
// [R12] Wrap from all ones to zero sets a sticky overflow flag.
`timescale 1ns/1ps
`include "gst_regs.vh"

module gst_timer
(
    input  wire                     ref_clk_i,
    input  wire                     rst_n_i,
    input  wire                     clk_en_i,
    input  wire                     timer_on_bit_i,
    input  wire                     gate_enable_bit_i,
    input  wire [`GST_CS_W-1:0]     clock_select_i,
    input  wire                     sync_mode_i,
    input  wire [`GST_PS_W-1:0]     prescale_sel_i,
    input  wire [`GST_GS_W-1:0]     gate_select_i,
    input  wire [3:0]               logic_cell_out_i,
    input  wire                     zero_cross_i,
    input  wire [1:0]               comparator_out_i,
    input  wire                     gate_input_pin_i,
    input  wire                     external_count_input_i,
    input  wire                     write_high_i,
    input  wire                     write_low_i,
    input  wire [`GST_BYTE_W-1:0]   write_data_i,
    input  wire                     overflow_clear_i,
    output wire [`GST_BYTE_W-1:0]   count_high_byte_o,
    output wire [`GST_BYTE_W-1:0]   count_low_byte_o,
    output wire                     overflow_o,
    output wire                     counting_o,
    output wire                     edge_armed_o
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg  [`GST_CNT_W-1:0]    count;
    reg  [`GST_CNT_W-1:0]    next_count;
    reg                      overflow;
    reg                      next_overflow;
    reg  [`GST_PHASE_W-1:0]  phase;
    reg  [`GST_PS_CNT_W-1:0] presc_cnt;
    reg  [`GST_PS_CNT_W-1:0] next_presc_cnt;
    reg                      ext_prev;
    reg                      armed;
    reg                      next_armed;
    reg                      pending;
    reg                      next_pending;
    reg                      counting;
    reg                      src_tick;
    reg                      inc;
    wire [`GST_PIN_N-1:0]    raw_pins;
    wire [`GST_PIN_N-1:0]    sync_pins;
    wire                     ext_level;
    wire                     ext_rise;
    wire                     ext_fall;
    wire                     instr_tick;
    wire                     gate_level;
    wire                     count_enable;
    wire                     any_write;
    wire [`GST_PS_CNT_W-1:0] presc_limit;
    wire                     restart;
    wire                     ext_sync_sel;
    wire                     presc_full;
    wire [`GST_PHASE_W-1:0]  next_phase;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function gate_pick;
        input [`GST_GS_W-1:0] sel;
        input [`GST_PIN_N-1:0] pins;
        begin
            case (sel)
                `GST_GS_CELL1: gate_pick = pins[0];
                `GST_GS_CELL2: gate_pick = pins[1];
                `GST_GS_CELL3: gate_pick = pins[2];
                `GST_GS_CELL4: gate_pick = pins[3];
                `GST_GS_ZCD:   gate_pick = pins[4];
                `GST_GS_CMP1:  gate_pick = pins[5];
                `GST_GS_CMP2:  gate_pick = pins[6];
                `GST_GS_PIN:   gate_pick = pins[7];
                default:       gate_pick = 1'b0;
            endcase
        end
    endfunction

    function [`GST_PS_CNT_W-1:0] presc_top;
        input [`GST_PS_W-1:0] sel;
        begin
            case (sel)
                `GST_PS_DIV1: presc_top = `GST_PS_TOP1;
                `GST_PS_DIV2: presc_top = `GST_PS_TOP2;
                `GST_PS_DIV4: presc_top = `GST_PS_TOP4;
                `GST_PS_DIV8: presc_top = `GST_PS_TOP8;
                default:      presc_top = `GST_PS_TOP1;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    assign raw_pins = {external_count_input_i, gate_input_pin_i,
                       comparator_out_i[1], comparator_out_i[0],
                       zero_cross_i, logic_cell_out_i};

    genvar gi;
    generate
        for (gi = 0; gi < `GST_PIN_N; gi = gi + 1)
        begin : g_sync
            gst_pin_sync u_sync
            (
                .ref_clk_i (ref_clk_i),
                .rst_n_i   (rst_n_i),
                .clk_en_i  (clk_en_i),
                .pin_i     (raw_pins[gi]),
                .level_o   (sync_pins[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Edge, gate and enable decode
    // ----------------------------------------------------------------
    assign ext_level    = sync_pins[`GST_PIN_EXT];
    assign ext_rise     = ext_level & ~ext_prev;
    assign ext_fall     = ~ext_level & ext_prev;
    assign gate_level   = gate_pick(gate_select_i, sync_pins); // [R9]
    assign count_enable = timer_on_bit_i
                          & (~gate_enable_bit_i | gate_level); // [R5]
    assign instr_tick   = (phase == `GST_PHASE_LAST);
    assign any_write    = write_high_i | write_low_i;
    assign presc_limit  = presc_top(prescale_sel_i);

    // ----------------------------------------------------------------
    // Restart and mode decode
    // ----------------------------------------------------------------
    assign restart      = any_write | ~timer_on_bit_i; // [R11]
    assign ext_sync_sel = sync_mode_i & (clock_select_i == `GST_CS_EXT); // [R10]
    assign presc_full   = (presc_cnt >= presc_limit);
    assign next_phase   = phase + `GST_PHASE_ONE;

    // ----------------------------------------------------------------
    // Falling edge arming and synchronous pending edge
    // ----------------------------------------------------------------
    always @*
    begin
        next_armed   = armed;
        next_pending = pending;
        if (restart)
        begin
            next_armed = 1'b0; // [R11]
        end
        else if (ext_fall)
        begin
            next_armed = 1'b1; // [R11]
        end
        // Stale pending edge must not survive a source change
        if (restart || !ext_sync_sel)
        begin
            next_pending = 1'b0;
        end
        else if (armed && ext_rise)
        begin
            next_pending = 1'b1; // [R10]
        end
        else if (instr_tick)
        begin
            next_pending = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Source tick selection
    // ----------------------------------------------------------------
    always @*
    begin
        case (clock_select_i) // [R6]
            `GST_CS_INSTR: src_tick = instr_tick; // [R3]
            `GST_CS_FOSC:  src_tick = 1'b1; // [R7] [R8]
            `GST_CS_EXT:
            begin
                if (sync_mode_i)
                begin
                    src_tick = pending & instr_tick; // [R10]
                end
                else
                begin
                    src_tick = armed & ext_rise; // [R4] [R10] [R11]
                end
            end
            default:       src_tick = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Prescaler and increment decision
    // ----------------------------------------------------------------
    always @*
    begin
        next_presc_cnt = presc_cnt;
        inc            = 1'b0;
        if (restart)
        begin
            next_presc_cnt = `GST_PS_CNT_RST;
        end
        else if (count_enable && src_tick)
        begin
            if (presc_full)
            begin
                next_presc_cnt = `GST_PS_CNT_RST;
                inc            = 1'b1; // [R7]
            end
            else
            begin
                next_presc_cnt = presc_cnt + `GST_PS_ONE;
            end
        end
    end

    // ----------------------------------------------------------------
    // Count and overflow next state
    // ----------------------------------------------------------------
    always @*
    begin
        next_count    = count;
        next_overflow = overflow;
        if (overflow_clear_i)
        begin
            next_overflow = 1'b0;
        end
        if (any_write)
        begin
            if (write_high_i)
            begin
                next_count[`GST_HI_MSB:`GST_HI_LSB] = write_data_i; // [R2]
            end
            if (write_low_i)
            begin
                next_count[`GST_LO_MSB:`GST_LO_LSB] = write_data_i; // [R2]
            end
        end
        else if (inc)
        begin
            next_count = count + `GST_CNT_ONE; // [R1]
            if (count == `GST_CNT_ALL_ONES)
            begin
                next_overflow = 1'b1; // [R12]
            end
        end
    end

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    always @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            count     <= `GST_CNT_RST;
            overflow  <= 1'b0;
            phase     <= `GST_PHASE_RST;
            presc_cnt <= `GST_PS_CNT_RST;
            ext_prev  <= 1'b0;
            armed     <= 1'b0;
            pending   <= 1'b0;
            counting  <= 1'b0;
        end
        else if (clk_en_i)
        begin
            count     <= next_count;
            overflow  <= next_overflow;
            phase     <= next_phase;
            presc_cnt <= next_presc_cnt;
            ext_prev  <= ext_level;
            armed     <= next_armed;
            pending   <= next_pending;
            counting  <= count_enable;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign count_high_byte_o = count[`GST_HI_MSB:`GST_HI_LSB]; // [R1]
    assign count_low_byte_o  = count[`GST_LO_MSB:`GST_LO_LSB]; // [R1]
    assign overflow_o        = overflow;
    assign counting_o        = counting;
    assign edge_armed_o      = armed;

endmodule // gst_timer

// file: testbench/gst_far_side.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// External count pin and gate sources
// ----------------------------------------------------------------
module gst_far_side
(
    input  wire       ref_clk_i,
    output reg        ext_o,
    output reg  [3:0] cell_o,
    output reg        zc_o,
    output reg  [1:0] cmp_o,
    output reg        pin_o
);
    initial {ext_o, cell_o, zc_o, cmp_o, pin_o} = 9'h000;

    // Selected source gets the level, all others the inverse
    task set_gate(input [2:0] sel, input lvl);
        reg [7:0] v;
    begin
        v = {8{~lvl}};
        v[sel] = lvl;
        {pin_o, cmp_o, zc_o, cell_o} <= v;
    end
    endtask

    // Pin rests low between pulses
    task pulses(input integer n);
    begin
        repeat (n)
        begin
            @(posedge ref_clk_i);
            ext_o <= 1'b1;
            repeat (8) @(posedge ref_clk_i);
            ext_o <= 1'b0;
            repeat (7) @(posedge ref_clk_i);
        end
    end
    endtask
endmodule // gst_far_side

// file: testbench/gst_timer_sva.sv
`timescale 1ns/1ps
`include "gst_regs.vh"

// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module gst_timer_sva
(
    input wire       ref_clk_i,
    input wire       rst_n_i,
    input wire       clk_en_i,
    input wire       timer_on_bit_i,
    input wire       gate_enable_bit_i,
    input wire [1:0] clock_select_i,
    input wire [1:0] prescale_sel_i,
    input wire       write_high_i,
    input wire       write_low_i,
    input wire [7:0] write_data_i,
    input wire       overflow_clear_i,
    input wire [7:0] count_high_byte_o,
    input wire [7:0] count_low_byte_o,
    input wire       overflow_o,
    input wire       counting_o,
    input wire       edge_armed_o
);
    wire [15:0] cnt = {count_high_byte_o, count_low_byte_o};
    wire        wr  = write_high_i | write_low_i;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    reset_clears_a: assert property (disable iff (1'b0) !rst_n_i |=>
        cnt == 16'h0 && !overflow_o && !edge_armed_o && !counting_o) else $error("reset state");
    write_low_a: assert property (clk_en_i && write_low_i |=>
        count_low_byte_o == $past(write_data_i)) else $error("low byte load");
    write_high_a: assert property (clk_en_i && write_high_i |=>
        count_high_byte_o == $past(write_data_i)) else $error("high byte load");
    frozen_hold_a: assert property (!clk_en_i |=> $stable(cnt) && $stable(overflow_o))
        else $error("frozen state moved");
    off_hold_a: assert property ((clk_en_i && !timer_on_bit_i && !wr)[*3] |=>
        $stable(cnt)) else $error("counted while off");
    none_hold_a: assert property ((clk_en_i && clock_select_i == `GST_CS_NONE && !wr)[*3]
        |=> $stable(cnt)) else $error("counted with no source");
    osc_step_a: assert property ((clk_en_i && timer_on_bit_i && !gate_enable_bit_i
        && !wr && clock_select_i == `GST_CS_FOSC && prescale_sel_i == 2'h0)[*3]
        |=> cnt == $past(cnt) + 16'h1) else $error("oscillator step");
    wrap_flag_a: assert property (clk_en_i && cnt == 16'hffff && !wr ##1 cnt == 16'h0
        |-> overflow_o) else $error("wrap without flag");
    flag_sticky_a: assert property (overflow_o && !overflow_clear_i |=> overflow_o)
        else $error("flag dropped");
    flag_clear_a: assert property (clk_en_i && overflow_clear_i && cnt != 16'hffff
        |=> !overflow_o) else $error("flag not cleared");
    off_idle_a: assert property (clk_en_i && !timer_on_bit_i |=> !counting_o)
        else $error("counting while off");
    write_disarm_a: assert property (clk_en_i && wr |=> !edge_armed_o)
        else $error("armed after write");

    cover property (cnt == 16'hffff ##1 cnt == 16'h0);
    cover property ($rose(edge_armed_o));
    cover property (clk_en_i && timer_on_bit_i && gate_enable_bit_i && counting_o);
endmodule // gst_timer_sva

bind gst_timer gst_timer_sva chk (.*);

// file: testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    reg        ref_clk_i = 1'b0;
    reg        rst_n_i = 1'b0;
    reg        clk_en_i = 1'b1;
    reg        timer_on_bit_i = 1'b0;
    reg        gate_enable_bit_i = 1'b0;
    reg  [1:0] clock_select_i = 2'h0;
    reg        sync_mode_i = 1'b0;
    reg  [1:0] prescale_sel_i = 2'h0;
    reg  [2:0] gate_select_i = 3'h0;
    reg        write_high_i = 1'b0;
    reg        write_low_i = 1'b0;
    reg  [7:0] write_data_i = 8'h00;
    reg        overflow_clear_i = 1'b0;
    wire [3:0] logic_cell_out_i;
    wire       zero_cross_i;
    wire [1:0] comparator_out_i;
    wire       gate_input_pin_i;
    wire       external_count_input_i;
    wire [7:0] count_high_byte_o;
    wire [7:0] count_low_byte_o;
    wire       overflow_o;
    wire       counting_o;
    wire       edge_armed_o;
    wire [15:0] cnt = {count_high_byte_o, count_low_byte_o};
    integer    miscompares = 0;
    integer    checks = 0;
    integer    i;
    reg [15:0] base;

    gst_timer uut (.*);
    gst_far_side far (.ref_clk_i(ref_clk_i), .ext_o(external_count_input_i),
        .cell_o(logic_cell_out_i), .zc_o(zero_cross_i), .cmp_o(comparator_out_i),
        .pin_o(gate_input_pin_i));

    initial forever #50 ref_clk_i = ~ref_clk_i;

    // ----------------------------------------------------------------
    // Access and compare tasks
    // ----------------------------------------------------------------
    task cyc(input integer n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task wr(input [15:0] v);
    begin
        @(posedge ref_clk_i);
        write_high_i <= 1'b1;
        write_data_i <= v[15:8];
        @(posedge ref_clk_i);
        write_high_i <= 1'b0;
        write_low_i  <= 1'b1;
        write_data_i <= v[7:0];
        @(posedge ref_clk_i);
        write_low_i  <= 1'b0;
    end
    endtask

    task chk(input [15:0] got, input [15:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("MISMATCH %0t count %h expected %h", $time, got, exp);
        end
    end
    endtask

    task chkb(input got, input exp);
    begin
        checks = checks + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
        end
    end
    endtask

    task run(input [1:0] cs, input [1:0] ps, input [15:0] v, input integer n, input [15:0] d);
    begin
        @(posedge ref_clk_i);
        clock_select_i <= cs;
        prescale_sel_i <= ps;
        cyc(8);
        wr(v);
        cyc(n);
        #1 chk(cnt, v + d);
    end
    endtask

    task test_done;
    begin
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        miscompares = miscompares + 1;
        test_done;
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        #1 chk(cnt, 16'h0000);
        chkb(overflow_o, 1'b0);
        chkb(edge_armed_o, 1'b0);
        chkb(counting_o, 1'b0);
        $display("test reset done");
        @(posedge ref_clk_i);
        timer_on_bit_i <= 1'b1;
        run(2'h0, 2'h0, 16'h1234, 40, 16'd10);
        for (i = 0; i < 4; i = i + 1)
            run(2'h1, i[1:0], 16'h0100, 80, 16'd80 >> i);
        $display("test sources done");
        @(posedge ref_clk_i);
        gate_enable_bit_i <= 1'b1;
        for (i = 0; i < 16; i = i + 1)
        begin
            @(posedge ref_clk_i);
            gate_select_i <= i[2:0];
            far.set_gate(i[2:0], i[3]);
            run(2'h1, 2'h0, 16'h0200, 40, i[3] ? 16'd40 : 16'd0);
            chkb(counting_o, i[3]);
        end
        @(posedge ref_clk_i);
        gate_enable_bit_i <= 1'b0;
        timer_on_bit_i <= 1'b0;
        run(2'h1, 2'h0, 16'h0300, 40, 16'd0);
        chkb(counting_o, 1'b0);
        @(posedge ref_clk_i);
        timer_on_bit_i <= 1'b1;
        run(2'h3, 2'h0, 16'h0300, 40, 16'd0);
        $display("test gating done");
        run(2'h1, 2'h0, 16'hfffe, 4, 16'd4);
        chkb(overflow_o, 1'b1);
        @(posedge ref_clk_i);
        clk_en_i <= 1'b0;
        @(posedge ref_clk_i);
        #1 base = cnt;
        cyc(5);
        #1 chk(cnt, base);
        @(posedge ref_clk_i);
        clk_en_i <= 1'b1;
        timer_on_bit_i <= 1'b0;
        overflow_clear_i <= 1'b1;
        @(posedge ref_clk_i);
        overflow_clear_i <= 1'b0;
        #1 chkb(overflow_o, 1'b0);
        $display("test overflow done");
        for (i = 0; i < 2; i = i + 1)
        begin
            @(posedge ref_clk_i);
            timer_on_bit_i <= 1'b1;
            clock_select_i <= 2'h2;
            sync_mode_i <= i[0];
            wr(16'h0000);
            #1 chkb(edge_armed_o, 1'b0);
            far.pulses(3);
            cyc(16);
            #1 chk(cnt, 16'h0002);
            chkb(edge_armed_o, 1'b1);
        end
        $display("test external done");
        test_done;
    end
endmodule // tb_top
